// ===== src/rscp_top.sv
`timescale 1ns/100ps
`default_nettype none

module rscp_top
    import rscp_pkg::*;
#(
    parameter int unsigned LOCK_HOLD = LOCK_CYCLES,
    // Bit period in clock cycles; the default gives 9600 baud.
    parameter int unsigned BIT_LEN   = BIT_CYCLES
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       rxd,
    input  wire logic       cts,
    input  wire logic       hs_enable,
    input  wire logic       tag_read,
    input  wire logic [3:0] tag_protocol,
    input  wire logic [3:0] protocol_enable,
    output logic            txd,
    output logic            rts,
    output logic            rf_on,
    output logic            cmd_mode,
    output logic            lock_closed
);

    // Receiver state.
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] next_rx_cnt;
    logic [3:0]       rx_bit;
    logic [3:0]       next_rx_bit;
    logic             rx_busy;
    logic             next_rx_busy;
    logic [7:0]       rx_sh;
    logic [7:0]       next_rx_sh;
    logic             rx_strobe;
    logic             next_rx_strobe;
    logic             rx_prev;

    // Command and reply state.
    logic [3:0]       digits [CMD_LEN];
    logic [3:0]       next_digits [CMD_LEN];
    logic [2:0]       ndig;
    logic [2:0]       next_ndig;
    logic             in_cmd;
    logic             next_in_cmd;
    logic             next_rf_on;
    logic             next_cmd_mode;
    logic             signed_on;
    logic             next_signed_on;
    logic             replying;
    logic             next_replying;
    logic [3:0]       msg_pos;
    logic [3:0]       next_msg_pos;
    logic [3:0]       msg_end;
    logic [3:0]       next_msg_end;

    // Lock timer.
    logic [31:0]      lock_cnt;
    logic [31:0]      next_lock_cnt;
    logic             next_lock_closed;

    logic             tx_ready;
    logic             tx_valid;
    logic [7:0]       tx_byte;
    logic             busy;
    logic [15:0]      code;

    // Text table: sign-on message, then the done reply, each ending in CR LF.
    function automatic logic [7:0] msg_char(input logic [3:0] idx);
        unique case (idx)
            4'h0:    msg_char = 8'h52;
            4'h1:    msg_char = 8'h45;
            4'h2:    msg_char = 8'h41;
            4'h3:    msg_char = 8'h44;
            4'h4:    msg_char = 8'h45;
            4'h5:    msg_char = 8'h52;
            4'h6:    msg_char = 8'h20;
            4'h7:    msg_char = CH_CR;
            4'h8:    msg_char = CH_LF;
            4'h9:    msg_char = CH_HASH;
            4'hA:    msg_char = 8'h44;
            4'hB:    msg_char = 8'h6F;
            4'hC:    msg_char = 8'h6E;
            4'hD:    msg_char = 8'h65;
            4'hE:    msg_char = CH_CR;
            default: msg_char = CH_LF;
        endcase
    endfunction : msg_char

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= CH_D0) && (c <= 8'h39);
    endfunction : is_digit

    assign busy     = replying || !signed_on;
    assign tx_valid = replying;
    assign tx_byte  = msg_char(msg_pos);
    assign code     = {digits[0], digits[1], digits[2], digits[3]};

    always_comb
    begin
        next_rx_cnt    = rx_cnt;
        next_rx_bit    = rx_bit;
        next_rx_busy   = rx_busy;
        next_rx_sh     = rx_sh;
        next_rx_strobe = 1'b0;
        if (!rx_busy)
        begin
            if (rx_prev && !rxd)
            begin
                next_rx_busy = 1'b1;
                next_rx_cnt  = CNT_W'(BIT_LEN / 2);
                next_rx_bit  = '0;
            end
        end
        else if (rx_cnt == CNT_W'(BIT_LEN - 1))
        begin
            next_rx_cnt = '0;
            next_rx_bit = rx_bit + 1'b1;
            if (rx_bit == 4'd0 && rxd)
            begin
                next_rx_busy = 1'b0;
            end
            else if (rx_bit <= 4'(DATA_BITS))
            begin
                next_rx_sh = {rxd, rx_sh[7:1]};
            end
            else
            begin
                // Stop bit sampled; a byte is kept only with a valid stop level.
                next_rx_busy   = 1'b0;
                next_rx_strobe = rxd;
            end
        end
        else
        begin
            next_rx_cnt = rx_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rx_cnt    <= '0;
            rx_bit    <= '0;
            rx_busy   <= 1'b0;
            rx_sh     <= '0;
            rx_strobe <= 1'b0;
            rx_prev   <= 1'b1;
        end
        else
        begin
            rx_cnt    <= next_rx_cnt;
            rx_bit    <= next_rx_bit;
            rx_busy   <= next_rx_busy;
            rx_sh     <= next_rx_sh;
            rx_strobe <= next_rx_strobe;
            rx_prev   <= rxd;
        end
    end

    always_comb
    begin
        next_digits    = digits;
        next_ndig      = ndig;
        next_in_cmd    = in_cmd;
        next_rf_on     = rf_on;
        next_cmd_mode  = cmd_mode;
        next_signed_on = signed_on;
        next_replying  = replying;
        next_msg_pos   = msg_pos;
        next_msg_end   = msg_end;
        if (!signed_on && !replying)
        begin
            next_replying = 1'b1;
            next_msg_pos  = MSG_SIGNON;
            next_msg_end  = 4'(SIGNON_LEN - 1);
        end
        if (replying && tx_ready)
        begin
            next_msg_pos = msg_pos + 1'b1;
            if (msg_pos == msg_end)
            begin
                next_replying  = 1'b0;
                next_signed_on = 1'b1;
            end
        end
        // Bytes arriving during sign-on or a reply are dropped.
        if (rx_strobe && !busy)
        begin
            if (rx_sh == CH_HASH)
            begin
                next_in_cmd = 1'b1;
                next_ndig   = '0;
                for (int i = 0; i < CMD_LEN; i++)
                begin
                    next_digits[i] = '0;
                end
            end
            else if (in_cmd && is_digit(rx_sh) && ndig < 3'(CMD_LEN - 1))
            begin
                next_digits[ndig] = rx_sh[3:0];
                next_ndig         = ndig + 1'b1;
            end
            else if (in_cmd && rx_sh == CH_CR)
            begin
                next_in_cmd = 1'b0;
                if (ndig == 3'd2 && code[15:8] == CMD_CMDMODE[7:0])
                begin
                    next_cmd_mode = 1'b1;
                    next_replying = 1'b1;
                end
                else if (ndig == 3'd2 && code[15:8] == CMD_DATAMODE[7:0])
                begin
                    next_cmd_mode = 1'b0;
                    next_replying = 1'b1;
                end
                else if (ndig == 3'd4 && code == CMD_RF_ON && cmd_mode)
                begin
                    next_rf_on    = 1'b1;
                    next_replying = 1'b1;
                end
                next_msg_pos = MSG_DONE;
                next_msg_end = 4'(MSG_DONE + DONE_LEN - 1);
            end
            else
            begin
                next_in_cmd = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CMD_LEN; i++)
            begin
                digits[i] <= '0;
            end
            ndig      <= '0;
            in_cmd    <= 1'b0;
            rf_on     <= RESET_RF;
            cmd_mode  <= RESET_CMDMODE;
            signed_on <= 1'b0;
            replying  <= 1'b0;
            msg_pos   <= '0;
            msg_end   <= '0;
        end
        else
        begin
            digits    <= next_digits;
            ndig      <= next_ndig;
            in_cmd    <= next_in_cmd;
            rf_on     <= next_rf_on;
            cmd_mode  <= next_cmd_mode;
            signed_on <= next_signed_on;
            replying  <= next_replying;
            msg_pos   <= next_msg_pos;
            msg_end   <= next_msg_end;
        end
    end

    always_comb
    begin
        next_lock_closed = lock_closed;
        next_lock_cnt    = lock_cnt;
        if (tag_read && rf_on && protocol_enable[tag_protocol[1:0]]
            && !tag_protocol[3] && !tag_protocol[2])
        begin
            next_lock_closed = 1'b1;
            next_lock_cnt    = LOCK_HOLD - 1;
        end
        else if (lock_cnt != 0)
        begin
            next_lock_cnt = lock_cnt - 1;
        end
        else
        begin
            next_lock_closed = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lock_cnt    <= '0;
            lock_closed <= 1'b0;
            rts         <= 1'b0;
        end
        else
        begin
            lock_cnt    <= next_lock_cnt;
            lock_closed <= next_lock_closed;
            rts         <= hs_enable;
        end
    end

    rscp_uart_tx #(
        .BIT_LEN  (BIT_LEN)
    ) u_tx (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .tx_valid (tx_valid),
        .tx_byte  (tx_byte),
        .cts_ok   (!hs_enable || cts),
        .tx_ready (tx_ready),
        .txd      (txd)
    );

endmodule : rscp_top

`default_nettype wire

// ===== src/rscp_pkg.sv
package rscp_pkg;

    // Serial framing: 9600 baud, 8 data bits, no parity, 1 stop bit.
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned BAUD          = 9600;
    localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned STOP_BITS     = 1;
    localparam int unsigned CNT_W         = 15;

    // Lock hold time after a read, in milliseconds, and its cycle count.
    localparam int unsigned LOCK_MS       = 500;
    localparam int unsigned LOCK_CYCLES   = (CLK_HZ / 1000) * LOCK_MS;

    localparam logic [7:0]  CH_HASH       = 8'h23;
    localparam logic [7:0]  CH_CR         = 8'h0D;
    localparam logic [7:0]  CH_LF         = 8'h0A;
    localparam logic [7:0]  CH_D0         = 8'h30;

    // Command buffer depth: '#' plus up to four digits.
    localparam int unsigned CMD_LEN       = 5;

    // Command codes as decimal digit strings packed four bits per digit.
    localparam logic [15:0] CMD_CMDMODE   = 16'h0001;
    localparam logic [15:0] CMD_DATAMODE  = 16'h0000;
    localparam logic [15:0] CMD_RF_ON     = 16'h6401;

    // Message lengths and indices into the transmit text table.
    localparam int unsigned SIGNON_LEN    = 9;
    localparam int unsigned DONE_LEN      = 7;
    localparam logic [3:0]  MSG_SIGNON    = 4'h0;
    localparam logic [3:0]  MSG_DONE      = 4'h9;

    localparam logic        RESET_RF      = 1'b0;
    localparam logic        RESET_CMDMODE = 1'b0;

    typedef enum logic [1:0] {
        RSCP_TX_IDLE  = 2'b00,
        RSCP_TX_START = 2'b01,
        RSCP_TX_DATA  = 2'b10,
        RSCP_TX_STOP  = 2'b11
    } rscp_tx_state_t;

endpackage : rscp_pkg

// ===== src/rscp_uart_tx.sv
`timescale 1ns/100ps
`default_nettype none

module rscp_uart_tx
    import rscp_pkg::*;
#(
    parameter int unsigned BIT_LEN = BIT_CYCLES
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       cts_ok,
    output logic            tx_ready,
    output logic            txd
);

    rscp_tx_state_t   state;
    rscp_tx_state_t   next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [2:0]       bit_idx;
    logic [2:0]       next_bit_idx;
    logic [7:0]       shreg;
    logic [7:0]       next_shreg;
    logic             next_txd;

    always_comb
    begin
        next_state   = state;
        next_cnt     = cnt;
        next_bit_idx = bit_idx;
        next_shreg   = shreg;
        next_txd     = txd;
        if (state != RSCP_TX_IDLE)
        begin
            next_cnt = (cnt == CNT_W'(BIT_LEN - 1)) ? '0 : cnt + 1'b1;
        end
        unique case (state)
            RSCP_TX_IDLE:
            begin
                // A frame starts only while cts_ok is high: CTS asserted, or handshake disabled.
                if (tx_valid && cts_ok)
                begin
                    next_state = RSCP_TX_START;
                    next_shreg = tx_byte;
                    next_txd   = 1'b0;
                    next_cnt   = '0;
                end
            end
            RSCP_TX_START:
            begin
                if (cnt == CNT_W'(BIT_LEN - 1))
                begin
                    next_state   = RSCP_TX_DATA;
                    next_bit_idx = '0;
                    next_txd     = shreg[0];
                end
            end
            RSCP_TX_DATA:
            begin
                if (cnt == CNT_W'(BIT_LEN - 1))
                begin
                    if (bit_idx == 3'(DATA_BITS - 1))
                    begin
                        next_state = RSCP_TX_STOP;
                        next_txd   = 1'b1;
                    end
                    else
                    begin
                        next_bit_idx = bit_idx + 1'b1;
                        next_txd     = shreg[3'(bit_idx + 1'b1)];
                    end
                end
            end
            RSCP_TX_STOP:
            begin
                if (cnt == CNT_W'(BIT_LEN * STOP_BITS - 1))
                begin
                    next_state = RSCP_TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state   <= RSCP_TX_IDLE;
            cnt     <= '0;
            bit_idx <= '0;
            shreg   <= '0;
            txd     <= 1'b1;
        end
        else
        begin
            state   <= next_state;
            cnt     <= next_cnt;
            bit_idx <= next_bit_idx;
            shreg   <= next_shreg;
            txd     <= next_txd;
        end
    end

    assign tx_ready = (state == RSCP_TX_IDLE) && cts_ok;

endmodule : rscp_uart_tx

`default_nettype wire

// ===== tb/rscp_top_chk.sv
`timescale 1ns/100ps
`default_nettype none

module rscp_top_chk
    import rscp_pkg::*;
#(
    parameter int unsigned LOCK_HOLD = LOCK_CYCLES,
    parameter int unsigned BIT_LEN   = BIT_CYCLES
)
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       rxd,
    input wire logic       cts,
    input wire logic       hs_enable,
    input wire logic       tag_read,
    input wire logic [3:0] tag_protocol,
    input wire logic [3:0] protocol_enable,
    input wire logic       txd,
    input wire logic       rts,
    input wire logic       rf_on,
    input wire logic       cmd_mode,
    input wire logic       lock_closed
);
    localparam int unsigned SIGNON_CYC = SIGNON_LEN * 10 * BIT_LEN;
    logic [31:0] since_rst;
    logic [31:0] hold_cnt;
    logic [31:0] low_cnt;
    logic        good_read;

    assign good_read = tag_read && rf_on && (tag_protocol[3:2] == 2'h0)
                       && protocol_enable[tag_protocol[1:0]];

    always_ff @(posedge ref_clk)
    begin
        since_rst <= !rst_n ? 32'h0 : (since_rst + {31'h0, ~&since_rst});
        hold_cnt  <= (!rst_n || good_read) ? 32'h0 : hold_cnt + {31'h0, lock_closed};
        low_cnt   <= (!rst_n || txd) ? 32'h0 : low_cnt + 32'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_rts_follows_enable: assert property ($past(rst_n) |-> rts == $past(hs_enable))
        else $error("rts does not follow handshake enable");
    a_lock_on_read: assert property (good_read |=> lock_closed)
        else $error("lock not closed after a valid read");
    a_lock_needs_read: assert property ($rose(lock_closed) |-> $past(good_read))
        else $error("lock closed without a valid read");
    a_lock_min_hold: assert property ($rose(lock_closed) |-> lock_closed [*8])
        else $error("lock released too soon");
    a_lock_max_hold: assert property (lock_closed |-> hold_cnt < LOCK_HOLD)
        else $error("lock held too long");
    a_rf_in_cmd_mode: assert property ($rose(rf_on) |-> cmd_mode)
        else $error("rf switched on outside command mode");
    a_rf_stays_on: assert property (rf_on |=> rf_on)
        else $error("rf switched off without reset");
    a_signon_first: assert property ($rose(cmd_mode) |-> since_rst > SIGNON_CYC)
        else $error("command taken during sign-on");
    a_cmd_at_stop: assert property ($changed(cmd_mode) |-> rxd && $past(rxd))
        else $error("mode changed away from a stop bit");
    a_bit_length: assert property ($rose(txd) |-> (low_cnt % BIT_LEN) == 0)
        else $error("txd low time not whole bits");

    c_cmd_enter: cover property ($rose(cmd_mode));
    c_cmd_leave: cover property ($fell(cmd_mode));
    c_rf_on: cover property ($rose(rf_on));
    c_lock: cover property ($rose(lock_closed));
endmodule : rscp_top_chk

bind rscp_top rscp_top_chk #(.LOCK_HOLD(LOCK_HOLD), .BIT_LEN(BIT_LEN)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .rxd(rxd), .cts(cts), .hs_enable(hs_enable),
    .tag_read(tag_read), .tag_protocol(tag_protocol), .protocol_enable(protocol_enable),
    .txd(txd), .rts(rts), .rf_on(rf_on), .cmd_mode(cmd_mode), .lock_closed(lock_closed));

`default_nettype wire

// ===== tb/rscp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module rscp_host_model
    import rscp_pkg::*;
#(
    parameter int unsigned BIT_LEN = BIT_CYCLES
)
(
    input  wire logic ref_clk,
    input  wire logic txd,
    output logic      rxd
);
    logic [8:0] rx_q[$];
    logic [8:0] shift;

    initial rxd = 1'b1;

    task automatic drive_bit(input logic b);
        @(posedge ref_clk);
        #1;
        rxd = b;
        repeat (BIT_LEN - 1) @(posedge ref_clk);
    endtask : drive_bit

    task automatic send_byte(input logic [7:0] b);
        drive_bit(1'b0);
        for (int i = 0; i < DATA_BITS; i++)
        begin
            drive_bit(b[i]);
        end
        drive_bit(1'b1);
    endtask : send_byte

    // Samples each reply bit in mid-bit and keeps the stop bit above the data.
    always
    begin
        @(negedge txd);
        repeat (BIT_LEN / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_LEN) @(posedge ref_clk);
            shift = {txd, shift[8:1]};
        end
        rx_q.push_back(shift);
    end
endmodule : rscp_host_model

`default_nettype wire

// ===== tb/tb_rscp_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_rscp_top
    import rscp_pkg::*;
;
    // A short bit period keeps the run small; framing is the same as at 9600 baud.
    localparam int unsigned LOCK_SIM   = 20;
    localparam int unsigned BIT_SIM    = 16;
    localparam int unsigned BYTE_CYC   = 10 * BIT_SIM;
    localparam int unsigned MAX_CYCLES = 100 * BYTE_CYC;

    logic       ref_clk;
    logic       rst_n;
    logic       rxd;
    logic       cts;
    logic       hs_enable;
    logic       tag_read;
    logic [3:0] tag_protocol;
    logic [3:0] protocol_enable;
    logic       txd;
    logic       rts;
    logic       rf_on;
    logic       cmd_mode;
    logic       lock_closed;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cycles = 0;

    rscp_top #(.LOCK_HOLD(LOCK_SIM), .BIT_LEN(BIT_SIM)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .rxd(rxd), .cts(cts), .hs_enable(hs_enable),
        .tag_read(tag_read), .tag_protocol(tag_protocol), .protocol_enable(protocol_enable),
        .txd(txd), .rts(rts), .rf_on(rf_on), .cmd_mode(cmd_mode), .lock_closed(lock_closed));

    rscp_host_model #(.BIT_LEN(BIT_SIM)) host (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++)
        begin
            host.send_byte(s[i]);
        end
        host.send_byte(CH_CR);
    endtask : send_line

    // Waits for a whole reply line and compares every byte with its stop bit.
    task automatic expect_line(input string s);
        logic [7:0] exp_q[$];
        int         w = 0;
        for (int i = 0; i < s.len(); i++)
        begin
            exp_q.push_back(s[i]);
        end
        exp_q.push_back(CH_CR);
        exp_q.push_back(CH_LF);
        while (host.rx_q.size() < exp_q.size() && w < (exp_q.size() + 2) * BYTE_CYC)
        begin
            tick(1);
            w++;
        end
        foreach (exp_q[i])
            check(host.rx_q.size() > 0 ? host.rx_q.pop_front() : 9'h000, {1'b1, exp_q[i]});
        check(9'(host.rx_q.size()), 9'h000);
    endtask : expect_line

    task automatic t_signon();
        fork
            send_line("#01");
            expect_line("READER ");
        join
        tick(2 * BYTE_CYC);
        check(9'(host.rx_q.size()), 9'h000);
        check({8'h00, cmd_mode}, 9'h000);
        $display("t_signon finished");
    endtask : t_signon

    task automatic t_modes();
        send_line("#6401");
        tick(2 * BYTE_CYC);
        check(9'(host.rx_q.size()), 9'h000);
        check({8'h00, rf_on}, 9'h000);
        send_line("#01");
        expect_line("#Done");
        check({8'h00, cmd_mode}, 9'h001);
        send_line("#6401");
        expect_line("#Done");
        check({8'h00, rf_on}, 9'h001);
        $display("t_modes finished");
    endtask : t_modes

    task automatic t_lock();
        tag_protocol = 4'h1;
        tag_read = 1'b1;
        tick(1);
        tag_read = 1'b0;
        tick(2);
        check({8'h00, lock_closed}, 9'h000);
        tag_protocol = 4'h2;
        tag_read = 1'b1;
        tick(1);
        tag_read = 1'b0;
        check({8'h00, lock_closed}, 9'h001);
        tick(LOCK_SIM - 1);
        check({8'h00, lock_closed}, 9'h001);
        tick(1);
        check({8'h00, lock_closed}, 9'h000);
        tag_protocol = 4'h6;
        tag_read = 1'b1;
        tick(1);
        tag_read = 1'b0;
        tick(2);
        check({8'h00, lock_closed}, 9'h000);
        $display("t_lock finished");
    endtask : t_lock

    task automatic t_back_and_handshake();
        send_line("#00");
        expect_line("#Done");
        check({7'h00, cmd_mode, rf_on}, 9'h001);
        hs_enable = 1'b1;
        cts = 1'b0;
        tick(2);
        check({8'h00, rts}, 9'h001);
        send_line("#01");
        tick(2 * BYTE_CYC);
        check(9'(host.rx_q.size()), 9'h000);
        cts = 1'b1;
        expect_line("#Done");
        check({8'h00, cmd_mode}, 9'h001);
        $display("t_back_and_handshake finished");
    endtask : t_back_and_handshake

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == MAX_CYCLES)
        begin
            n_mismatch++;
            $display("timeout after %0d cycles", cycles);
            test_done();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        cts = 1'b1;
        hs_enable = 1'b0;
        tag_read = 1'b0;
        tag_protocol = 4'h0;
        protocol_enable = 4'h4;
        repeat (8) @(posedge ref_clk);
        #1;
        check({4'h0, txd, rts, rf_on, cmd_mode, lock_closed}, 9'h010);
        rst_n = 1'b1;
        t_signon();
        t_modes();
        t_lock();
        t_back_and_handshake();
        test_done();
    end
endmodule : tb_rscp_top

`default_nettype wire
